// >>> design/lcdio_defines.svh
`ifndef LCDIO_DEFINES_SVH
`define LCDIO_DEFINES_SVH

// register word indices; byte address is index times four
`define LCDIO_IDX_PORT_D     10'h008
`define LCDIO_IDX_PORT_E     10'h009
`define LCDIO_IDX_DIR_D      10'h088
`define LCDIO_IDX_DIR_E      10'h089
`define LCDIO_IDX_PORT_F     10'h107
`define LCDIO_IDX_PORT_G     10'h108
`define LCDIO_IDX_SEGEN      10'h10D
`define LCDIO_IDX_DIR_F      10'h187
`define LCDIO_IDX_DIR_G      10'h188
`define LCDIO_IDX_BITOP      10'h110

// reset values
`define LCDIO_RST_LATCH      8'h00
`define LCDIO_RST_DIR        8'hFF
`define LCDIO_RST_SEGEN      8'hFF

// segment enable bit positions
`define LCDIO_SE_ZERO        0
`define LCDIO_SE_FIVE        1
`define LCDIO_SE_NINE        2
`define LCDIO_SE_TWELVE      3
`define LCDIO_SE_SIXTEEN     4
`define LCDIO_SE_TWENTY      5
`define LCDIO_SE_TWENTYSEVEN 6
`define LCDIO_SE_TWENTYNINE  7

// port group codes
`define LCDIO_PORT_D         2'h0
`define LCDIO_PORT_E         2'h1
`define LCDIO_PORT_F         2'h2
`define LCDIO_PORT_G         2'h3

// bit operation register fields
`define LCDIO_BITOP_BIT_MSB  2
`define LCDIO_BITOP_BIT_LSB  0
`define LCDIO_BITOP_VAL      3
`define LCDIO_BITOP_PORT_MSB 5
`define LCDIO_BITOP_PORT_LSB 4

`endif

// >>> design/lcdio_pkg.sv
package lcdio_pkg;
    typedef logic [7:0]  lcdio_byte_t;
    typedef logic [31:0] lcdio_word_t;
    typedef logic [1:0]  lcdio_port_t;
    typedef enum logic [0:0] {
        ST_IDLE,
        ST_MODIFY
    } lcdio_state_t;
endpackage

// >>> design/lcdio_ports.sv
// Notes on behaviour
// - port D bits 0-4 are bidirectional pins or LCD segments 0-4.
// - port D bits 5-7 are inputs or segments 29-31 or commons 3-1.
// - port E is input only; bits 0-6 segments 5-11, bit 7 segment 27.
// - port F is input only; bits 0-7 are segments 12-19.
// - port G is input only; bits 0-6 segments 20-26, bit 7 segment 28.
// - segments 27 and 28 are absent on the reduced package.
// - after reset every shared pin belongs to the LCD driver.
// - a set segment enable bit drives its pins from LCD, ignoring direction.
// - group twelve and sixteen enables release all port F pins.
// - groups five and nine cover E bits 0-6; group 27 covers E7, G7.
// - group twenty enable covers port G bits 0-6.
// - port reads return pin levels; writes update the output latch.
// - each port write reads the pin levels first, then writes back.
// - read-modify-write takes pins, applies the op, stores all eight bits.
// - an input pin's latch takes its sampled level during a bit operation write.
// - port D direction enables outputs on bits 0-4 in port mode only.
`timescale 1ns/10ps
`default_nettype none
`include "lcdio_defines.svh"

module lcdio_ports #(
    parameter bit REDUCED_PACKAGE = 1'b0
) (
    // clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire lcdio_pkg::lcdio_word_t pwdata,
    output var  lcdio_pkg::lcdio_word_t prdata,
    output logic                      pready,
    output logic                      pslverr,
    // lcd driver levels
    input  wire logic [31:0]          lcd_seg_level,
    input  wire logic [2:0]           lcd_com_level,
    input  wire logic [2:0]           lcd_com_mode,
    // port d pads
    input  wire lcdio_pkg::lcdio_byte_t pad_d_in,
    output var  lcdio_pkg::lcdio_byte_t pad_d_out,
    output var  lcdio_pkg::lcdio_byte_t pad_d_oe,
    // port e pads
    input  wire lcdio_pkg::lcdio_byte_t pad_e_in,
    output var  lcdio_pkg::lcdio_byte_t pad_e_out,
    output var  lcdio_pkg::lcdio_byte_t pad_e_oe,
    // port f pads
    input  wire lcdio_pkg::lcdio_byte_t pad_f_in,
    output var  lcdio_pkg::lcdio_byte_t pad_f_out,
    output var  lcdio_pkg::lcdio_byte_t pad_f_oe,
    // port g pads
    input  wire lcdio_pkg::lcdio_byte_t pad_g_in,
    output var  lcdio_pkg::lcdio_byte_t pad_g_out,
    output var  lcdio_pkg::lcdio_byte_t pad_g_oe
);
    import lcdio_pkg::*;

    // pick one port group's byte out of a packed 32-bit vector
    function automatic lcdio_byte_t pick_byte(input lcdio_word_t v,
                                              input lcdio_port_t p);
        pick_byte = v[{p, 3'b000} +: 8];
    endfunction

    // which pins of a group the LCD driver owns
    function automatic lcdio_byte_t seg_mask(input lcdio_byte_t se,
                                             input lcdio_port_t p);
        logic ext;
        ext = se[`LCDIO_SE_TWENTYSEVEN] & ~REDUCED_PACKAGE;
        case (p)
            `LCDIO_PORT_D: seg_mask = {{3{se[`LCDIO_SE_TWENTYNINE]}},
                                       {5{se[`LCDIO_SE_ZERO]}}};
            `LCDIO_PORT_E: seg_mask = {ext, {3{se[`LCDIO_SE_NINE]}},
                                       {4{se[`LCDIO_SE_FIVE]}}};
            `LCDIO_PORT_F: seg_mask = {{4{se[`LCDIO_SE_SIXTEEN]}},
                                       {4{se[`LCDIO_SE_TWELVE]}}};
            default:       seg_mask = {ext,
                                       {7{se[`LCDIO_SE_TWENTY]}}};
        endcase
    endfunction

    // set or clear one bit of a byte
    function automatic lcdio_byte_t apply_bit(input lcdio_byte_t b,
                                              input logic [2:0]  n,
                                              input logic        v);
        apply_bit = b;
        apply_bit[n] = v;
    endfunction

    // registers
    lcdio_byte_t  latch_reg [4];
    lcdio_byte_t  dir_reg [4];
    lcdio_byte_t  segen_reg;
    lcdio_byte_t  rmw_reg;
    lcdio_state_t state_reg;
    lcdio_state_t state_next;
    lcdio_word_t  prdata_reg;
    lcdio_word_t  pin_s1_reg;
    lcdio_word_t  pin_s2_reg;
    lcdio_word_t  pin_s3_reg;
    lcdio_word_t  lvl_reg;
    lcdio_word_t  lvl_next;
    lcdio_word_t  pad_out_reg;
    lcdio_word_t  pad_out_next;
    lcdio_word_t  pad_oe_reg;
    lcdio_word_t  pad_oe_next;

    // address decode
    wire logic [9:0]  idx      = paddr[11:2];
    wire logic        aligned  = (paddr[1:0] == 2'b00);
    wire logic        hit_pd   = aligned && (idx == `LCDIO_IDX_PORT_D);
    wire logic        hit_pe   = aligned && (idx == `LCDIO_IDX_PORT_E);
    wire logic        hit_pf   = aligned && (idx == `LCDIO_IDX_PORT_F);
    wire logic        hit_pg   = aligned && (idx == `LCDIO_IDX_PORT_G);
    wire logic        hit_dd   = aligned && (idx == `LCDIO_IDX_DIR_D);
    wire logic        hit_de   = aligned && (idx == `LCDIO_IDX_DIR_E);
    wire logic        hit_df   = aligned && (idx == `LCDIO_IDX_DIR_F);
    wire logic        hit_dg   = aligned && (idx == `LCDIO_IDX_DIR_G);
    wire logic        hit_seg  = aligned && (idx == `LCDIO_IDX_SEGEN);
    wire logic        hit_bop  = aligned && (idx == `LCDIO_IDX_BITOP);
    wire logic        val_hit  = hit_pd | hit_pe | hit_pf | hit_pg;
    wire logic        dir_hit  = hit_dd | hit_de | hit_df | hit_dg;
    wire logic        mapped   = val_hit | dir_hit | hit_seg | hit_bop;
    wire lcdio_port_t val_port = hit_pe ? `LCDIO_PORT_E :
                                 hit_pf ? `LCDIO_PORT_F :
                                 hit_pg ? `LCDIO_PORT_G : `LCDIO_PORT_D;
    wire lcdio_port_t dir_port = hit_de ? `LCDIO_PORT_E :
                                 hit_df ? `LCDIO_PORT_F :
                                 hit_dg ? `LCDIO_PORT_G : `LCDIO_PORT_D;
    wire lcdio_port_t bop_port =
        pwdata[`LCDIO_BITOP_PORT_MSB:`LCDIO_BITOP_PORT_LSB];
    wire lcdio_port_t tgt_port = hit_bop ? bop_port : val_port;

    // bus phases
    wire logic setup    = psel && !penable;
    wire logic access   = psel && penable;
    wire logic port_wr  = access && pwrite && (val_hit || hit_bop);
    wire logic capture  = port_wr && (state_reg == ST_IDLE);
    wire logic latch_we = port_wr && (state_reg == ST_MODIFY);
    wire logic cfg_wr   = access && pwrite;

    // port write result: whole byte, or one bit on captured pins
    wire lcdio_byte_t rmw_result =
        hit_bop ? apply_bit(rmw_reg,
                            pwdata[`LCDIO_BITOP_BIT_MSB:`LCDIO_BITOP_BIT_LSB],
                            pwdata[`LCDIO_BITOP_VAL])
                : pwdata[7:0];

    // read mux
    wire lcdio_byte_t rd_byte =
        val_hit ? pick_byte(lvl_reg, val_port) :
        dir_hit ? dir_reg[dir_port] :
        hit_seg ? segen_reg : 8'h00;

    // port writes wait one cycle for the pin read
    assign pready  = !capture;
    assign pslverr = access && !mapped;
    assign prdata  = prdata_reg;

    // pins as seen by the port: three flops, change when last two agree
    wire lcdio_word_t pin_raw = {pad_g_in, pad_f_in, pad_e_in, pad_d_in};
    assign lvl_next = (pin_s2_reg & pin_s3_reg) |
                      (lvl_reg & (pin_s2_reg ^ pin_s3_reg));

    // LCD levels arranged by port pin
    wire lcdio_byte_t lcd_d;
    wire lcdio_byte_t lcd_e = {lcd_seg_level[27], lcd_seg_level[11:5]};
    wire lcdio_byte_t lcd_f = lcd_seg_level[19:12];
    wire lcdio_byte_t lcd_g = {lcd_seg_level[28], lcd_seg_level[26:20]};
    assign lcd_d[4:0] = lcd_seg_level[4:0];
    assign lcd_d[5]   = lcd_com_mode[0] ? lcd_com_level[2]
                                        : lcd_seg_level[29];
    assign lcd_d[6]   = lcd_com_mode[1] ? lcd_com_level[1]
                                        : lcd_seg_level[30];
    assign lcd_d[7]   = lcd_com_mode[2] ? lcd_com_level[0]
                                        : lcd_seg_level[31];

    wire lcdio_byte_t msk_d = seg_mask(segen_reg, `LCDIO_PORT_D);
    wire lcdio_byte_t msk_e = seg_mask(segen_reg, `LCDIO_PORT_E);
    wire lcdio_byte_t msk_f = seg_mask(segen_reg, `LCDIO_PORT_F);
    wire lcdio_byte_t msk_g = seg_mask(segen_reg, `LCDIO_PORT_G);

    // LCD owns masked pins; only port D bits 0-4 may drive digitally
    wire lcdio_byte_t dig_oe_d = {3'b000, ~dir_reg[0][4:0]};
    assign pad_oe_next  = {msk_g, msk_f, msk_e,
                           msk_d | (~msk_d & dig_oe_d)};
    assign pad_out_next = {lcd_g & msk_g, lcd_f & msk_f, lcd_e & msk_e,
                           (lcd_d & msk_d) | (latch_reg[0] & ~msk_d)};

    assign pad_d_out = pad_out_reg[7:0];
    assign pad_e_out = pad_out_reg[15:8];
    assign pad_f_out = pad_out_reg[23:16];
    assign pad_g_out = pad_out_reg[31:24];
    assign pad_d_oe  = pad_oe_reg[7:0];
    assign pad_e_oe  = pad_oe_reg[15:8];
    assign pad_f_oe  = pad_oe_reg[23:16];
    assign pad_g_oe  = pad_oe_reg[31:24];

    assign state_next = capture ? ST_MODIFY : ST_IDLE;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_reg <= 32'h0000_0000;
            pin_s2_reg <= 32'h0000_0000;
            pin_s3_reg <= 32'h0000_0000;
            lvl_reg    <= 32'h0000_0000;
        end else begin
            pin_s1_reg <= pin_raw;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            lvl_reg    <= lvl_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_out_reg <= 32'h0000_0000;
            pad_oe_reg  <= 32'h0000_0000;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            pad_out_reg <= pad_out_next;
            pad_oe_reg  <= pad_oe_next;
            if (setup) begin
                prdata_reg <= {24'h00_0000, rd_byte};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            rmw_reg   <= `LCDIO_RST_LATCH;
        end else begin
            state_reg <= state_next;
            if (capture) begin
                rmw_reg <= pick_byte(lvl_reg, tgt_port);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            segen_reg <= `LCDIO_RST_SEGEN;
            for (int i = 0; i < 4; i++) begin
                latch_reg[i] <= `LCDIO_RST_LATCH;
                dir_reg[i]   <= `LCDIO_RST_DIR;
            end
        end else begin
            if (latch_we) begin
                latch_reg[tgt_port] <= rmw_result;
            end
            if (cfg_wr && dir_hit) begin
                dir_reg[dir_port] <= pwdata[7:0];
            end
            if (cfg_wr && hit_seg) begin
                segen_reg <= pwdata[7:0];
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_port_capture;
        capture;
    endsequence

    sequence s_port_commit;
        latch_we && pready;
    endsequence

    AST_POR_LCD_OWNS: assert property (
        !$past(presetn) |-> segen_reg == `LCDIO_RST_SEGEN
    ) else $error("segment enables not all set after reset");

    AST_SEG_OVERRIDE_D: assert property (
        segen_reg[`LCDIO_SE_ZERO] |=>
            pad_d_oe[4:0] == 5'h1F &&
            pad_d_out[4:0] == $past(lcd_seg_level[4:0])
    ) else $error("port d low pins not driven by lcd");

    AST_DIR_D_PORT_MODE: assert property (
        !segen_reg[`LCDIO_SE_ZERO] |=>
            pad_d_oe[4:0] == ~$past(dir_reg[0][4:0])
    ) else $error("port d output enable does not follow direction");

    AST_D_HIGH_INPUT_ONLY: assert property (
        !segen_reg[`LCDIO_SE_TWENTYNINE] |=> pad_d_oe[7:5] == 3'b000
    ) else $error("port d input-only pin driven");

    AST_F_RELEASE: assert property (
        !segen_reg[`LCDIO_SE_TWELVE] && !segen_reg[`LCDIO_SE_SIXTEEN] |=>
            pad_f_oe == 8'h00
    ) else $error("port f not released");

    AST_EG_BIT7_GROUP: assert property (
        segen_reg[`LCDIO_SE_TWENTYSEVEN] |=>
            pad_e_oe[7] == !REDUCED_PACKAGE &&
            pad_g_oe[7] == !REDUCED_PACKAGE
    ) else $error("e7 and g7 not governed together");

    AST_G_LOW_GROUP: assert property (
        segen_reg[`LCDIO_SE_TWENTY] |=>
            pad_g_oe[6:0] == 7'h7F &&
            pad_g_out[6:0] == $past(lcd_seg_level[26:20])
    ) else $error("port g low pins not driven by lcd");

    AST_READ_PINS: assert property (
        setup && !pwrite && hit_pf |=> prdata[7:0] == $past(lvl_reg[23:16])
    ) else $error("port f read does not return pin levels");

    AST_RMW_TAKES_PINS: assert property (
        s_port_capture |=> !pready == 1'b0 &&
            rmw_reg == pick_byte($past(lvl_reg), $past(tgt_port))
    ) else $error("port write did not read pins first");

    AST_RMW_STORE: assert property (
        s_port_capture ##1 s_port_commit |=>
            latch_reg[$past(tgt_port)] == $past(rmw_result)
    ) else $error("port write result not stored in latch");

    AST_RMW_TWO_STEP: assert property (
        s_port_capture |-> !pready ##1 s_port_commit
    ) else $error("port write not split into read and write");

    AST_D_HIGH_LCD: assert property (
        segen_reg[`LCDIO_SE_TWENTYNINE] |=>
            pad_d_oe[7:5] == 3'b111 &&
            pad_d_out[5] == $past(lcd_com_mode[0] ? lcd_com_level[2]
                                                  : lcd_seg_level[29]) &&
            pad_d_out[7] == $past(lcd_com_mode[2] ? lcd_com_level[0]
                                                  : lcd_seg_level[31])
    ) else $error("port d high pins not driven by lcd");

    AST_E_LOW_GROUP: assert property (
        segen_reg[`LCDIO_SE_FIVE] && segen_reg[`LCDIO_SE_NINE] |=>
            pad_e_oe[6:0] == 7'h7F &&
            pad_e_out[6:0] == $past(lcd_seg_level[11:5])
    ) else $error("port e low pins not driven by lcd");

    AST_F_LCD_GROUP: assert property (
        segen_reg[`LCDIO_SE_TWELVE] && segen_reg[`LCDIO_SE_SIXTEEN] |=>
            pad_f_oe == 8'hFF && pad_f_out == $past(lcd_seg_level[19:12])
    ) else $error("port f pins not driven by lcd");

    AST_BIT7_LCD_LEVEL: assert property (
        segen_reg[`LCDIO_SE_TWENTYSEVEN] && !REDUCED_PACKAGE |=>
            pad_e_out[7] == $past(lcd_seg_level[27]) &&
            pad_g_out[7] == $past(lcd_seg_level[28])
    ) else $error("e7 or g7 not driven by its segment");

    AST_EXT_SEG_PRESENCE: assert property (
        1'b1 |=>
            pad_e_oe[7] == ($past(segen_reg[`LCDIO_SE_TWENTYSEVEN]) &&
                            !REDUCED_PACKAGE) &&
            pad_g_oe[7] == pad_e_oe[7]
    ) else $error("e7 or g7 drive does not match package");

    AST_NO_DIGITAL_DRIVE: assert property (
        segen_reg == 8'h00 |=>
            pad_e_oe == 8'h00 && pad_f_oe == 8'h00 &&
            pad_g_oe == 8'h00 && pad_d_oe[7:5] == 3'b000
    ) else $error("input-only pin driven in port mode");

    AST_PORT_D_LATCH: assert property (
        !segen_reg[`LCDIO_SE_ZERO] |=>
            pad_d_out[4:0] == $past(latch_reg[0][4:0])
    ) else $error("port d pins do not show the output latch");

    AST_LATCH_HOLD: assert property (
        !latch_we |=> latch_reg[0] == $past(latch_reg[0])
    ) else $error("port d latch changed without a port write");

    AST_SYNC_LEVEL: assert property (
        pin_s2_reg == pin_s3_reg |=> lvl_reg == $past(pin_s2_reg)
    ) else $error("pin level did not follow agreeing samples");

    AST_READ_NO_WAIT: assert property (
        access && !pwrite |-> pready
    ) else $error("read held in wait state");

endmodule

`default_nettype wire

// >>> test/lcdio_pad_model.sv
`timescale 1ns/10ps
`default_nettype none

module lcdio_pad_model (
    // pad side of the block, groups g f e d from top
    input  wire logic [31:0] pad_out,
    input  wire logic [31:0] pad_oe,
    // levels of outside drivers on released pins
    input  wire logic [31:0] ext_level,
    output logic      [31:0] pad_level
);
    // a driven pad shows the block, a released one the outside level
    assign pad_level = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule

`default_nettype wire

// >>> test/test_lcd_shared_io_ports.sv
`timescale 1ns/10ps
`default_nettype none
`include "lcdio_defines.svh"

module test_lcd_shared_io_ports;
    import lcdio_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    lcdio_word_t pwdata = 0, prdata, exq[$];
    logic        pready, pslverr;
    logic [31:0] seed = 32'hDEE8, ext = 0, lcd_segment_output = 0, pins;
    logic [2:0]  com_l = 0, com_m = 0;
    lcdio_byte_t segen, dir_d, lat_d;
    lcdio_byte_t pad_d_in, pad_d_out, pad_d_oe, pad_e_in, pad_e_out, pad_e_oe;
    lcdio_byte_t pad_f_in, pad_f_out, pad_f_oe, pad_g_in, pad_g_out, pad_g_oe;
    logic [9:0]  dir_idx [4] = '{`LCDIO_IDX_DIR_D, `LCDIO_IDX_DIR_E,
                                 `LCDIO_IDX_DIR_F, `LCDIO_IDX_DIR_G};
    logic [9:0]  port_idx [4] = '{`LCDIO_IDX_PORT_D, `LCDIO_IDX_PORT_E,
                                  `LCDIO_IDX_PORT_F, `LCDIO_IDX_PORT_G};
    int          fail_count = 0, num_checks = 0, k;

    always #5 pclk = ~pclk;

    lcdio_ports #(.REDUCED_PACKAGE(1'b0)) lcdio_ports_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .lcd_seg_level(lcd_segment_output),
        .lcd_com_level(com_l), .lcd_com_mode(com_m),
        .pad_d_in(pad_d_in), .pad_d_out(pad_d_out), .pad_d_oe(pad_d_oe),
        .pad_e_in(pad_e_in), .pad_e_out(pad_e_out), .pad_e_oe(pad_e_oe),
        .pad_f_in(pad_f_in), .pad_f_out(pad_f_out), .pad_f_oe(pad_f_oe),
        .pad_g_in(pad_g_in), .pad_g_out(pad_g_out), .pad_g_oe(pad_g_oe));

    lcdio_pad_model lcdio_pad_model_inst (
        .pad_out({pad_g_out, pad_f_out, pad_e_out, pad_d_out}),
        .pad_oe({pad_g_oe, pad_f_oe, pad_e_oe, pad_d_oe}),
        .ext_level(ext), .pad_level(pins));
    assign {pad_g_in, pad_f_in, pad_e_in, pad_d_in} = pins;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    // segment and common levels each pad carries when handed to the lcd
    function automatic logic [31:0] lcd_vec();
        logic [7:0] dh;
        dh = {com_m[2] ? com_l[0] : lcd_segment_output[31], com_m[1] ? com_l[1] : lcd_segment_output[30],
              com_m[0] ? com_l[2] : lcd_segment_output[29], lcd_segment_output[4:0]};
        return {lcd_segment_output[28], lcd_segment_output[26:20], lcd_segment_output[19:12], lcd_segment_output[27], lcd_segment_output[11:5], dh};
    endfunction

    function automatic logic [31:0] mask_vec();
        return {segen[6], {7{segen[5]}}, {4{segen[4]}}, {4{segen[3]}},
                segen[6], {3{segen[2]}}, {4{segen[1]}}, {3{segen[7]}},
                {5{segen[0]}}};
    endfunction

    task automatic compare_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_pads();
        logic [31:0] m, eo, ev, go, gv;
        m  = mask_vec();
        eo = m | {27'h0, ~dir_d[4:0]};
        ev = (m & lcd_vec()) | (~m & {27'h0, lat_d[4:0]});
        go = {pad_g_oe, pad_f_oe, pad_e_oe, pad_d_oe};
        gv = {pad_g_out, pad_f_out, pad_e_out, pad_d_out};
        compare_word(go, eo);
        compare_word(gv & eo, ev & eo);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1 check_pads();
        @(posedge pclk);
    endtask

    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic wr, input logic [9:0] idx,
                       input lcdio_word_t d, input lcdio_word_t exp,
                       input logic err);
        int n, en;
        // port value and bit-op writes take one wait state
        en = 1;
        for (int j = 0; j < 4; j++) if (wr && idx == port_idx[j]) en = 2;
        if (wr && idx == `LCDIO_IDX_BITOP) en = 2;
        if (!wr) exq.push_back(exp);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        compare_word(n, en);
        compare_word({31'h0, pslverr}, {31'h0, err});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [9:0] idx, input lcdio_word_t d);
        apb(1'b1, idx, d, 32'h0, 1'b0);
    endtask

    task automatic rd(input logic [9:0] idx, input lcdio_word_t exp);
        apb(1'b0, idx, 32'h0, exp, 1'b0);
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            compare_word(prdata, exq.pop_front());
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge pclk);
        fail_count++;
        complete_run();
    end

    initial begin
        seed = xs(seed);
        lcd_segment_output <= seed;
        seed = xs(seed);
        ext <= seed;
        com_l <= seed[2:0];
        segen = 8'hFF;
        dir_d = 8'hFF;
        lat_d = 8'h00;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        settle(3);
        for (k = 0; k < 4; k++) rd(dir_idx[k], 32'hFF);
        rd(`LCDIO_IDX_SEGEN, 32'hFF);
        for (k = 0; k < 4; k++)
            rd(port_idx[k], (lcd_vec() >> (8*k)) & 32'hFF);
        $display("test reset values done");
        for (k = 0; k < 8; k++) begin
            segen = ~(8'h01 << k);
            com_m <= k[2:0];
            seed = xs(seed);
            lcd_segment_output <= seed;
            wr(`LCDIO_IDX_SEGEN, {24'h0, segen});
            settle(1);
        end
        $display("test segment enables done");
        segen = 8'h00;
        wr(`LCDIO_IDX_SEGEN, 32'h0);
        dir_d = 8'h00;
        wr(`LCDIO_IDX_DIR_D, 32'h0);
        seed = xs(seed);
        lat_d = seed[7:0];
        wr(`LCDIO_IDX_PORT_D, {24'h0, lat_d});
        for (k = 1; k < 4; k++) begin
            wr(dir_idx[k], 32'h0);
            wr(port_idx[k], 32'hFF);
        end
        seed = xs(seed);
        ext <= seed;
        settle(6);
        rd(`LCDIO_IDX_PORT_D, {24'h0, ext[7:5], lat_d[4:0]});
        for (k = 1; k < 4; k++)
            rd(port_idx[k], (ext >> (8*k)) & 32'hFF);
        $display("test digital port mode done");
        dir_d = 8'h01;
        wr(`LCDIO_IDX_DIR_D, 32'h01);
        lat_d = 8'h00;
        wr(`LCDIO_IDX_PORT_D, 32'h0);
        ext <= ext | 32'h1;
        repeat (6) @(posedge pclk);
        wr(`LCDIO_IDX_BITOP, 32'h0B);
        lat_d = {ext[7:5], 4'h0, 1'b1} | 8'h08;
        dir_d = 8'h00;
        wr(`LCDIO_IDX_DIR_D, 32'h0);
        settle(6);
        wr(`LCDIO_IDX_BITOP, 32'h00);
        lat_d = {ext[7:5], lat_d[4:1], 1'b0};
        settle(1);
        $display("test bit operations done");
        apb(1'b0, 10'h3FF, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 10'h3FF, 32'hFF, 32'h0, 1'b1);
        rd(`LCDIO_IDX_SEGEN, 32'h0);
        rd(`LCDIO_IDX_BITOP, 32'h0);
        $display("test unmapped access done");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        segen = 8'hFF;
        dir_d = 8'hFF;
        lat_d = 8'h00;
        settle(2);
        rd(`LCDIO_IDX_DIR_D, 32'hFF);
        $display("test second reset done");
        complete_run();
    end
endmodule

`default_nettype wire
